// [rtl/wes_defs.vh]
// Purpose: Offsets, field positions and reset values of the wake and
//          management status bank
// Assumes: Register byte address is four times its index
// Notes:   Definitions only
`ifndef WES_DEFS_VH
`define WES_DEFS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define WES_IDX_WAKE_EN 8'h0E
`define WES_IDX_RSVD 8'h0F
`define WES_IDX_STS1 8'h10
`define WES_IDX_EN1 8'h16
`define WES_IDX_WAKE_STS 8'h30
`define WES_IDX_WAKE_CTL 8'h31

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WES_RST_WAKE_EN 8'h00
`define WES_RST_STS1 8'h02
`define WES_RST_EN1 8'h00
`define WES_RST_WAKE_STS 8'h00
`define WES_RST_WAKE_CTL 1'b0

// ----------------------------------------------------------------
// Status register one fields
// ----------------------------------------------------------------
`define WES_STS1_PAR 1
`define WES_STS1_SER2 2
`define WES_STS1_SER1 3
`define WES_STS1_FLOPPY 4
`define WES_STS1_MIDI 5
`define WES_STS1_WDOG 7
`define WES_STS1_MASK 8'hBE

// ----------------------------------------------------------------
// Wake control fields
// ----------------------------------------------------------------
`define WES_CTL_GLOBAL 0

`endif

// [rtl/wes_wake_latch.v]
// Purpose: Sticky wake status for port-5 pins and wake request gating
// Assumes: Pins synchronous to pclk; presetn is standby power-on reset
// Notes:   A rising pin edge in the clear cycle keeps its status bit set
`include "wes_defs.vh"

module wes_wake_latch #(
    parameter WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] pins,
    input wire [WIDTH-1:0] clear_mask,
    input wire [WIDTH-1:0] wake_enable,
    input wire global_enable,
    output wire [WIDTH-1:0] wake_status,
    output wire wake_request_n
);

    reg [WIDTH-1:0] pins_d_r;
    reg [WIDTH-1:0] status_r;
    wire [WIDTH-1:0] event_w;
    wire [WIDTH-1:0] status_nxt;

    // ----------------------------------------------------------------
    // Event capture
    // ----------------------------------------------------------------
    assign event_w = pins & ~pins_d_r;
    assign status_nxt = (status_r & ~clear_mask) | event_w;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_d_r <= {WIDTH{1'b0}};
            status_r <= {WIDTH{1'b0}};
        end else begin
            pins_d_r <= pins;
            status_r <= status_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Wake request
    // ----------------------------------------------------------------
    assign wake_status = status_r;
    assign wake_request_n = ~(global_enable & (|(status_r & wake_enable)));

endmodule // wes_wake_latch

// [rtl/wes_mgmt_status.v]
// Purpose: Live mirror of peripheral interrupt lines and group output
// Assumes: Sources are levels cleared at their peripheral
// Notes:   Status reflects sources one clock after they change
`include "wes_defs.vh"

module wes_mgmt_status (
    input wire pclk,
    input wire presetn,
    input wire other_reset,
    input wire parallel_port_active,
    input wire printer_acknowledge_n,
    input wire serial_port2_irq,
    input wire serial_port1_irq,
    input wire floppy_irq,
    input wire midi_port_irq,
    input wire watchdog_irq,
    input wire [7:0] enable_one,
    output wire [7:0] status_one,
    output wire group_mgmt_irq_n
);

    reg [7:0] status_r;
    reg [7:0] status_nxt;

    // ----------------------------------------------------------------
    // Source mirror
    // ----------------------------------------------------------------
    always @* begin
        status_nxt = 8'h00;
        status_nxt[`WES_STS1_PAR] = parallel_port_active ? printer_acknowledge_n : 1'b1;
        status_nxt[`WES_STS1_SER2] = serial_port2_irq;
        status_nxt[`WES_STS1_SER1] = serial_port1_irq;
        status_nxt[`WES_STS1_FLOPPY] = floppy_irq;
        status_nxt[`WES_STS1_MIDI] = midi_port_irq;
        status_nxt[`WES_STS1_WDOG] = watchdog_irq;
        if (other_reset) begin
            status_nxt[`WES_STS1_PAR] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= `WES_RST_STS1;
        end else begin
            status_r <= status_nxt & `WES_STS1_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Group output
    // ----------------------------------------------------------------
    assign status_one = status_r;
    assign group_mgmt_irq_n = ~(|(status_r & enable_one & `WES_STS1_MASK));

endmodule // wes_mgmt_status

// [rtl/wes_bank.v]
// Purpose: APB register bank for port-5 wake enables and management
//          interrupt status one
// Assumes: presetn is the standby power-on reset; other resets are
//          synchronous inputs that leave the wake enables alone
// Notes:   Zero wait states; unmapped addresses answer with pslverr
//
// Summary of operation
// - Enabled wake status with global enable drives wake request low.
// - Disabled sources still record status but never drive wake request.
// - Eight-bit read/write wake enable at index 0E, bit n for pin n.
// - Wake enable clears only on standby power-on reset.
// - Index 0F is reserved and reads zero.
// - Status one at index 10; sources are cleared at the peripheral.
// - Bit 1 reads one while parallel port inactive, and follows acknowledge while active.
// - Status defaults 02; bit 1 forced one by every reset.
// - Bits 2..5 serial2, serial1, floppy, MIDI; bit 7 watchdog; 0,6 reserved.
// - Each status bit reaches group output only when enable one bit set.
//
// The APB interface to the registers was chosen for this implementation.
`include "wes_defs.vh"

module wes_bank #(
    parameter AW = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata,
    input wire main_por_n,
    input wire hard_reset,
    input wire soft_reset,
    input wire [7:0] gpio_port5,
    input wire parallel_port_active,
    input wire printer_acknowledge_n,
    input wire serial_port2_irq,
    input wire serial_port1_irq,
    input wire floppy_irq,
    input wire midi_port_irq,
    input wire watchdog_irq,
    output wire wake_request_n,
    output wire group_mgmt_irq_n
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function hit;
        input [AW-1:0] addr;
        input [7:0] idx;
        begin
            hit = (addr == {{(AW-10){1'b0}}, idx, 2'b00});
        end
    endfunction

    wire sel_wake_en = hit(paddr, `WES_IDX_WAKE_EN);
    wire sel_rsvd = hit(paddr, `WES_IDX_RSVD);
    wire sel_sts1 = hit(paddr, `WES_IDX_STS1);
    wire sel_en1 = hit(paddr, `WES_IDX_EN1);
    wire sel_wake_sts = hit(paddr, `WES_IDX_WAKE_STS);
    wire sel_wake_ctl = hit(paddr, `WES_IDX_WAKE_CTL);
    wire mapped = sel_wake_en | sel_rsvd | sel_sts1 | sel_en1 | sel_wake_sts | sel_wake_ctl;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite & pstrb[0];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [7:0] wake_enable_port5_r;
    reg [7:0] mgmt_irq_enable_one_r;
    reg wake_global_enable_r;
    reg [31:0] prdata_r;
    reg [31:0] prdata_nxt;
    wire [7:0] wake_status;
    wire [7:0] status_one;
    wire [7:0] wake_clear = (wr && sel_wake_sts) ? pwdata[7:0] : 8'h00;
    wire other_reset = ~main_por_n | hard_reset | soft_reset;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_enable_port5_r <= `WES_RST_WAKE_EN;
            mgmt_irq_enable_one_r <= `WES_RST_EN1;
            wake_global_enable_r <= `WES_RST_WAKE_CTL;
        end else begin
            if (wr && sel_wake_en) begin
                wake_enable_port5_r <= pwdata[7:0];
            end
            if (wr && sel_en1) begin
                mgmt_irq_enable_one_r <= pwdata[7:0] & `WES_STS1_MASK;
            end
            if (wr && sel_wake_ctl) begin
                wake_global_enable_r <= pwdata[`WES_CTL_GLOBAL];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @* begin
        prdata_nxt = 32'h0000_0000;
        if (sel_wake_en) begin
            prdata_nxt[7:0] = wake_enable_port5_r;
        end else if (sel_rsvd) begin
            prdata_nxt = 32'h0000_0000;
        end else if (sel_sts1) begin
            prdata_nxt[7:0] = status_one;
        end else if (sel_en1) begin
            prdata_nxt[7:0] = mgmt_irq_enable_one_r;
        end else if (sel_wake_sts) begin
            prdata_nxt[7:0] = wake_status;
        end else if (sel_wake_ctl) begin
            prdata_nxt[`WES_CTL_GLOBAL] = wake_global_enable_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= prdata_nxt;
        end
    end

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_r;

    // ----------------------------------------------------------------
    // Sub-blocks; status one has no write path
    // ----------------------------------------------------------------
    wes_wake_latch #(
        .WIDTH(8)
    ) u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .pins(gpio_port5),
        .clear_mask(wake_clear),
        .wake_enable(wake_enable_port5_r),
        .global_enable(wake_global_enable_r),
        .wake_status(wake_status),
        .wake_request_n(wake_request_n)
    );

    wes_mgmt_status u_mgmt (
        .pclk(pclk),
        .presetn(presetn),
        .other_reset(other_reset),
        .parallel_port_active(parallel_port_active),
        .printer_acknowledge_n(printer_acknowledge_n),
        .serial_port2_irq(serial_port2_irq),
        .serial_port1_irq(serial_port1_irq),
        .floppy_irq(floppy_irq),
        .midi_port_irq(midi_port_irq),
        .watchdog_irq(watchdog_irq),
        .enable_one(mgmt_irq_enable_one_r),
        .status_one(status_one),
        .group_mgmt_irq_n(group_mgmt_irq_n)
    );

endmodule // wes_bank

// [test/wes_periph.sv]
// Purpose: Peripheral interrupt sources
// Assumes: Raise and clear pulses sync to pclk
// Notes: Sources clear only here
module wes_periph (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] raise,
    input wire logic [4:0] clear,
    output logic [4:0] irq
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq <= 5'h00;
        else irq <= (irq | raise) & ~clear;
    end
endmodule // wes_periph

// [test/wes_bank_props.sv]
// Purpose: Port checks of the bank
// Assumes: Status latency one clock
// Notes: Bound to wes_bank
module wes_bank_chk #(
    parameter AW = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire main_por_n,
    input wire hard_reset,
    input wire soft_reset,
    input wire [7:0] gpio_port5,
    input wire parallel_port_active,
    input wire printer_acknowledge_n,
    input wire serial_port2_irq,
    input wire serial_port1_irq,
    input wire floppy_irq,
    input wire midi_port_irq,
    input wire watchdog_irq,
    input wire wake_request_n,
    input wire group_mgmt_irq_n
);
    logic [7:0] we_r;
    logic [7:0] en_r;
    wire b1 = !parallel_port_active | printer_acknowledge_n | hard_reset | soft_reset | !main_por_n;
    wire [7:0] src = {watchdog_irq, 1'b0, midi_port_irq, floppy_irq, serial_port1_irq,
        serial_port2_irq, b1, 1'b0};
    wire wr = psel & penable & pwrite & pstrb[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            we_r <= 8'h00;
            en_r <= 8'h00;
        end else if (wr && paddr == 12'h038) begin
            we_r <= pwdata[7:0];
        end else if (wr && paddr == 12'h058) begin
            en_r <= pwdata[7:0] & 8'hBE;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_at(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence rd_sts;
        rd_at(12'h040) ##0 $past(presetn, 2);
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    rsvd_zero_a: assert property (rd_at(12'h03C) |=> prdata == 32'h0) else $error("rsvd");
    wake_read_a: assert property (rd_at(12'h038) |=> prdata[7:0] == $past(we_r))
        else $error("wake enable read");
    wake_gate_a: assert property (we_r == 8'h00 |-> wake_request_n) else $error("gate");
    wake_hold_a: assert property ($changed(wake_request_n) |-> $past(wr) ||
        ($past(gpio_port5) & ~$past(gpio_port5, 2)) != 8'h00) else $error("wake changed");
    sts_map_a: assert property (rd_sts |=> prdata == {24'h0, $past(src, 2)})
        else $error("status map");
    grp_src_a: assert property (!group_mgmt_irq_n == |(en_r & $past(src)))
        else $error("group");
    unmapped_err_a: assert property (psel && penable && paddr == 12'h044 |-> pslverr)
        else $error("no error");
endmodule // wes_bank_chk
bind wes_bank wes_bank_chk #(.AW(AW)) chk (.*);

// [test/tb_top.sv]
// Purpose: Bank self-check
// Assumes: Zero wait APB
// Notes: Sources from wes_periph
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, wq_n, gp_n, por_n = 1, hrst = 0, srst = 0, pact = 0, ack_n = 0;
    logic [7:0] gpio = 0;
    logic [3:0] stb = 4'hF;
    logic [4:0] raise = 0, clear = 0, irq;
    int n_fail = 0, checked = 0, cyc = 0;
    always #2 pclk = ~pclk;
    wes_periph src (.pclk(pclk), .presetn(presetn), .raise(raise), .clear(clear), .irq(irq));
    wes_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(stb), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .main_por_n(por_n), .hard_reset(hrst),
        .soft_reset(srst), .gpio_port5(gpio), .parallel_port_active(pact),
        .printer_acknowledge_n(ack_n), .serial_port2_irq(irq[0]), .serial_port1_irq(irq[1]),
        .floppy_irq(irq[2]), .midi_port_irq(irq[3]), .watchdog_irq(irq[4]),
        .wake_request_n(wq_n), .group_mgmt_irq_n(gp_n));
    task automatic summarize;
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        xf(0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic t_reset;
        rc("wake_en", 12'h038, 32'h00000000);
        rc("rsvd", 12'h03C, 32'h00000000);
        chk("slverr_ok", 32'h0, {31'h0, err});
        rc("sts1", 12'h040, 32'h00000002);
        rc("unmapped", 12'h044, 32'h00000000);
        chk("slverr", 32'h1, {31'h0, err});
    endtask
    task automatic t_wake;
        xf(1, 12'h038, 32'h000000A5);
        rc("wake_en", 12'h038, 32'h000000A5);
        stb <= 4'h0;
        xf(1, 12'h038, 32'h0000005A);
        stb <= 4'hF;
        rc("wake_strb", 12'h038, 32'h000000A5);
        xf(1, 12'h0C4, 32'h00000001);
        xf(1, 12'h03C, 32'h000000FF);
        rc("rsvd_wr", 12'h03C, 32'h00000000);
        gpio <= 8'h02;
        repeat (2) @(posedge pclk);
        chk("wreq_dis", 32'h1, {31'h0, wq_n});
        rc("wake_sts", 12'h0C0, 32'h00000002);
        gpio <= 8'h03;
        repeat (2) @(posedge pclk);
        chk("wreq_en", 32'h0, {31'h0, wq_n});
        xf(1, 12'h0C4, 32'h00000000);
        @(posedge pclk);
        chk("wreq_glob", 32'h1, {31'h0, wq_n});
        xf(1, 12'h0C4, 32'h00000001);
        hrst <= 1;
        srst <= 1;
        por_n <= 0;
        repeat (2) @(posedge pclk);
        hrst <= 0;
        srst <= 0;
        por_n <= 1;
        rc("wake_kept", 12'h038, 32'h000000A5);
        xf(1, 12'h038, 32'h00000000);
        @(posedge pclk);
        chk("wreq_gate", 32'h1, {31'h0, wq_n});
    endtask
    task automatic t_status;
        pact <= 1;
        raise <= 5'h1F;
        @(posedge pclk);
        raise <= 5'h00;
        repeat (3) @(posedge pclk);
        rc("sts_map", 12'h040, 32'h000000BC);
        xf(1, 12'h040, 32'h00000000);
        rc("sts_wr", 12'h040, 32'h000000BC);
        chk("grp_off", 32'h1, {31'h0, gp_n});
        xf(1, 12'h058, 32'h00000080);
        @(posedge pclk);
        chk("grp_on", 32'h0, {31'h0, gp_n});
        clear <= 5'h10;
        @(posedge pclk);
        clear <= 5'h00;
        repeat (3) @(posedge pclk);
        chk("grp_clr", 32'h1, {31'h0, gp_n});
        ack_n <= 1;
        repeat (3) @(posedge pclk);
        rc("sts_ack", 12'h040, 32'h0000003E);
        ack_n <= 0;
        pact <= 0;
        repeat (3) @(posedge pclk);
        rc("sts_idle", 12'h040, 32'h0000003E);
        pact <= 1;
        srst <= 1;
        repeat (3) @(posedge pclk);
        rc("sts_srst", 12'h040, 32'h0000003E);
        srst <= 0;
    endtask
    task automatic t_por;
        xf(1, 12'h038, 32'h0000005A);
        pact <= 0;
        gpio <= 8'h00;
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rc("por_wake_en", 12'h038, 32'h00000000);
        rc("por_sts1", 12'h040, 32'h00000002);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_wake();
        t_status();
        t_por();
        summarize();
    end
endmodule // tb_top
